// [shared/tfpa_defines.vh]
// Constants for the trim fuse page overlay: offsets, fields, reset values and timing
`ifndef TFPA_DEFINES_VH
`define TFPA_DEFINES_VH

// I/O RAM addresses of the two control registers
`define TFPA_ADDR_PAGE_CTRL 16'h270b
`define TFPA_ADDR_CODE_LOC 16'h2109

// Field positions
`define TFPA_PAGE_SELECT_BIT 0
`define TFPA_CODE_LOC_MSB 5
`define TFPA_CODE_LOC_LSB 0
`define TFPA_CODE_LOC_W 6

// Reset values
`define TFPA_PAGE_SELECT_RST 1'b0
`define TFPA_CODE_LOC_RST 6'h00

// Overlay geometry: one page of 1024 bytes on a 1024-byte boundary
`define TFPA_PAGE_BYTES 1024
`define TFPA_PAGE_OFS_W 10

// Trim object offsets inside the page
`define TFPA_OFS_TEMP_HOT_HIGH 10'h090
`define TFPA_OFS_TEMP_HOT_LOW 10'h091
`define TFPA_OFS_REF_HOT_HIGH 10'h092
`define TFPA_OFS_REF_HOT_LOW 10'h093
`define TFPA_OFS_REF_ROOM 10'h094

// Object widths
`define TFPA_TEMP_W 11
`define TFPA_REF_HOT_W 16
`define TFPA_REF_ROOM_W 8

// Value of any unused byte of the page
`define TFPA_BLANK_BYTE 8'h00

// Settle time of the fuse sense amplifiers after reset, in ns
`define TFPA_FUSE_SETTLE_NS 200
`define TFPA_CLK_PERIOD_NS 10
`define TFPA_FUSE_SETTLE_CYC \
  ((`TFPA_FUSE_SETTLE_NS + `TFPA_CLK_PERIOD_NS - 1) / `TFPA_CLK_PERIOD_NS)
`define TFPA_SETTLE_CNT_W 8

`endif

// [src/tfpa_fuse_store.v]
// Byte lookup of the trim fuse page from the latched fuse words
`default_nettype none
`include "tfpa_defines.vh"

module tfpa_fuse_store (
  input wire [`TFPA_PAGE_OFS_W-1:0] page_offset,
  input wire [`TFPA_TEMP_W-1:0] temp_hot,
  input wire [`TFPA_REF_HOT_W-1:0] ref_hot,
  input wire [`TFPA_REF_ROOM_W-1:0] ref_room,
  output reg [7:0] page_byte
);

  always @* begin
    case (page_offset)
      `TFPA_OFS_TEMP_HOT_HIGH: page_byte = {5'h00, temp_hot[10:8]};
      `TFPA_OFS_TEMP_HOT_LOW: page_byte = temp_hot[7:0];
      `TFPA_OFS_REF_HOT_HIGH: page_byte = ref_hot[15:8];
      `TFPA_OFS_REF_HOT_LOW: page_byte = ref_hot[7:0];
      `TFPA_OFS_REF_ROOM: page_byte = ref_room;
      default: page_byte = `TFPA_BLANK_BYTE;
    endcase
  end

endmodule

`default_nettype wire

// [src/tfpa_trim_page.v]
// Trim fuse page overlay on program memory, with its two I/O RAM control registers
//
// Notes on behaviour
// - While page select is set, program reads in the page window return trim page bytes.
// - The page window starts at 1024 times the code location field.
// - Trim values never appear on the I/O RAM read port, only through the overlay.
// - An 11-bit two's complement 85 C temperature sits at offsets 0x90 (10:8) and 0x91 (7:0).
// - A 16-bit hot reference deviation sits high byte at 0x92 and low byte at 0x93.
// - An 8-bit room temperature reference deviation sits at offset 0x94.
// - A byte with fewer than eight valid bits holds them from bit zero upward.
// - Trim objects are read only and reached by program memory reads, never data writes.
`default_nettype none
`include "tfpa_defines.vh"

module tfpa_trim_page #(
  parameter ADDR_W = 16,
  parameter SETTLE_CYC = `TFPA_FUSE_SETTLE_CYC
) (
  input wire mclk,
  input wire sys_rst,
  // I/O RAM register port from the processor
  input wire [ADDR_W-1:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  output reg io_hit,
  output reg io_valid,
  // Program memory fetch port from the processor
  input wire [ADDR_W-1:0] pm_addr,
  input wire pm_rd,
  output reg [7:0] pm_rdata,
  output reg pm_valid,
  output reg pm_from_trim,
  // Flash array data for the address on pm_addr, same cycle
  input wire [7:0] flash_rdata,
  // Raw fuse macro outputs, static after power up
  input wire [`TFPA_TEMP_W-1:0] fuse_temp_hot,
  input wire [`TFPA_REF_HOT_W-1:0] fuse_ref_hot,
  input wire [`TFPA_REF_ROOM_W-1:0] fuse_ref_room,
  // Status levels
  output wire trim_page_select,
  output wire [`TFPA_CODE_LOC_W-1:0] code_location_base,
  output reg fuse_ready
);

  localparam ST_SETTLE = 2'h0;
  localparam ST_LATCH = 2'h1;
  localparam ST_READY = 2'h2;

  reg page_select;
  reg [`TFPA_CODE_LOC_W-1:0] code_loc;
  reg [1:0] fuse_state;
  reg [1:0] next_fuse_state;
  reg [`TFPA_SETTLE_CNT_W-1:0] settle_cnt;

  // Two-stage synchronisers on the fuse macro outputs
  reg [`TFPA_TEMP_W-1:0] temp_sync1;
  reg [`TFPA_TEMP_W-1:0] temp_sync2;
  reg [`TFPA_REF_HOT_W-1:0] ref_hot_sync1;
  reg [`TFPA_REF_HOT_W-1:0] ref_hot_sync2;
  reg [`TFPA_REF_ROOM_W-1:0] ref_room_sync1;
  reg [`TFPA_REF_ROOM_W-1:0] ref_room_sync2;

  // Shadow copies used by the overlay
  reg [`TFPA_TEMP_W-1:0] temp_hot;
  reg [`TFPA_REF_HOT_W-1:0] ref_hot;
  reg [`TFPA_REF_ROOM_W-1:0] ref_room;

  wire [7:0] page_byte;
  wire in_window;
  wire page_hit;

  assign trim_page_select = page_select;
  assign code_location_base = code_loc;

  // window on a 1KB boundary
  // Base built at full width so a 16-bit bus needs no zero-length padding
  function window_match;
    input [ADDR_W-1:0] addr;
    input [`TFPA_CODE_LOC_W-1:0] loc;
    reg [ADDR_W-1:0] base;
    begin
      base = {ADDR_W{1'b0}};
      base[`TFPA_CODE_LOC_W+`TFPA_PAGE_OFS_W-1:`TFPA_PAGE_OFS_W] = loc;
      window_match = (addr[ADDR_W-1:`TFPA_PAGE_OFS_W] ==
        base[ADDR_W-1:`TFPA_PAGE_OFS_W]);
    end
  endfunction

  function io_match;
    input [ADDR_W-1:0] addr;
    input [15:0] reg_addr;
    begin
      io_match = (addr == reg_addr[ADDR_W-1:0]);
    end
  endfunction

  assign in_window = window_match(pm_addr, code_loc);
  assign page_hit = page_select & in_window;

  // Control registers; only the processor writes them
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      page_select <= `TFPA_PAGE_SELECT_RST;
      code_loc <= `TFPA_CODE_LOC_RST;
    end else if (io_wr) begin
      if (io_match(io_addr, `TFPA_ADDR_PAGE_CTRL)) begin
        page_select <= io_wdata[`TFPA_PAGE_SELECT_BIT];
      end
      if (io_match(io_addr, `TFPA_ADDR_CODE_LOC)) begin
        code_loc <= io_wdata[`TFPA_CODE_LOC_MSB:`TFPA_CODE_LOC_LSB];
      end
    end
  end

  // no trim data on the I/O read path
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      io_rdata <= 8'h00;
      io_hit <= 1'b0;
      io_valid <= 1'b0;
    end else begin
      io_valid <= io_rd;
      if (io_rd) begin
        if (io_match(io_addr, `TFPA_ADDR_PAGE_CTRL)) begin
          io_rdata <= {7'h00, page_select};
          io_hit <= 1'b1;
        end else if (io_match(io_addr, `TFPA_ADDR_CODE_LOC)) begin
          io_rdata <= {2'h0, code_loc};
          io_hit <= 1'b1;
        end else begin
          io_rdata <= 8'h00;
          io_hit <= 1'b0;
        end
      end
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_sync1 <= {`TFPA_TEMP_W{1'b0}};
      temp_sync2 <= {`TFPA_TEMP_W{1'b0}};
      ref_hot_sync1 <= {`TFPA_REF_HOT_W{1'b0}};
      ref_hot_sync2 <= {`TFPA_REF_HOT_W{1'b0}};
      ref_room_sync1 <= {`TFPA_REF_ROOM_W{1'b0}};
      ref_room_sync2 <= {`TFPA_REF_ROOM_W{1'b0}};
    end else begin
      temp_sync1 <= fuse_temp_hot;
      temp_sync2 <= temp_sync1;
      ref_hot_sync1 <= fuse_ref_hot;
      ref_hot_sync2 <= ref_hot_sync1;
      ref_room_sync1 <= fuse_ref_room;
      ref_room_sync2 <= ref_room_sync1;
    end
  end

  // Fuse sense amplifiers need time after reset before their outputs mean anything
  always @* begin
    next_fuse_state = fuse_state;
    case (fuse_state)
      ST_SETTLE: begin
        if (settle_cnt == SETTLE_CYC[`TFPA_SETTLE_CNT_W-1:0]) begin
          next_fuse_state = ST_LATCH;
        end
      end
      ST_LATCH: next_fuse_state = ST_READY;
      ST_READY: next_fuse_state = ST_READY;
      default: next_fuse_state = ST_SETTLE;
    endcase
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      fuse_state <= ST_SETTLE;
      settle_cnt <= {`TFPA_SETTLE_CNT_W{1'b0}};
      fuse_ready <= 1'b0;
      temp_hot <= {`TFPA_TEMP_W{1'b0}};
      ref_hot <= {`TFPA_REF_HOT_W{1'b0}};
      ref_room <= {`TFPA_REF_ROOM_W{1'b0}};
    end else begin
      fuse_state <= next_fuse_state;
      if (fuse_state == ST_SETTLE) begin
        settle_cnt <= settle_cnt + 1'b1;
      end
      // shadows are loaded once and never written by software
      if (fuse_state == ST_LATCH) begin
        temp_hot <= temp_sync2;
        ref_hot <= ref_hot_sync2;
        ref_room <= ref_room_sync2;
        fuse_ready <= 1'b1;
      end
    end
  end

  tfpa_fuse_store u_store (
    .page_offset(pm_addr[`TFPA_PAGE_OFS_W-1:0]),
    .temp_hot(temp_hot),
    .ref_hot(ref_hot),
    .ref_room(ref_room),
    .page_byte(page_byte)
  );

  // Program fetch answer one cycle after the request
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pm_rdata <= 8'h00;
      pm_valid <= 1'b0;
      pm_from_trim <= 1'b0;
    end else begin
      pm_valid <= pm_rd;
      if (pm_rd) begin
        pm_from_trim <= page_hit;
        if (page_hit) begin
          pm_rdata <= page_byte;
        end else begin
          pm_rdata <= flash_rdata;
        end
      end
    end
  end

endmodule

`default_nettype wire

// [test/tfpa_flash_model.sv]
// Flash array model answering fetches outside the trim page
`default_nettype none
module tfpa_flash_model (
  input wire logic [15:0] addr,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Byte differs per address so a stale or trim byte shows
  assign data = addr[7:0] ^ addr[15:8] ^ 8'h5a;
endmodule
`default_nettype wire

// [test/tfpa_trim_page_properties.sv]
// Checker for the trim page overlay ports
`default_nettype none
module tfpa_trim_page_chk #(parameter ADDR_W = 16) (
  input wire mclk,
  input wire sys_rst,
  input wire io_rd,
  input wire [7:0] io_rdata,
  input wire io_hit,
  input wire io_valid,
  input wire [ADDR_W-1:0] pm_addr,
  input wire pm_rd,
  input wire [7:0] pm_rdata,
  input wire pm_valid,
  input wire pm_from_trim,
  input wire [7:0] flash_rdata,
  input wire [10:0] fuse_temp_hot,
  input wire [15:0] fuse_ref_hot,
  input wire [7:0] fuse_ref_room,
  input wire trim_page_select,
  input wire [5:0] code_location_base,
  input wire fuse_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire hit = pm_rd && trim_page_select && pm_addr[15:10] == code_location_base;
  wire fr = hit && fuse_ready;
  wire [9:0] ofs = pm_addr[9:0];
  pm_answer_a: assert property (pm_rd |=> pm_valid) else $error("fetch not answered");
  io_answer_a: assert property (io_rd |=> io_valid) else $error("read not answered");
  trim_hit_a: assert property (hit |=> pm_from_trim)
    else $error("overlay fetch not from page");
  base_miss_a: assert property (pm_rd && pm_addr[15:10] != code_location_base
    |=> !pm_from_trim) else $error("page seen off base");
  flash_pass_a: assert property (pm_rd && !trim_page_select |=>
    !pm_from_trim && pm_rdata == $past(flash_rdata)) else $error("flash not passed");
  io_hide_a: assert property (io_valid && !io_hit |-> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  temp_pad_a: assert property (fr && ofs == 10'h090
    |=> pm_rdata == {5'h00, fuse_temp_hot[10:8]}) else $error("temp high wrong");
  ref_high_a: assert property (fr && ofs == 10'h092
    |=> pm_rdata == fuse_ref_hot[15:8]) else $error("ref high wrong");
  room_ref_a: assert property (fr && ofs == 10'h094
    |=> pm_rdata == fuse_ref_room) else $error("room ref wrong");
endmodule
bind tfpa_trim_page tfpa_trim_page_chk #(.ADDR_W(ADDR_W)) chk_u (.mclk, .sys_rst, .io_rd,
  .io_rdata, .io_hit, .io_valid, .pm_addr, .pm_rd, .pm_rdata, .pm_valid, .pm_from_trim,
  .flash_rdata, .fuse_temp_hot, .fuse_ref_hot, .fuse_ref_room, .trim_page_select,
  .code_location_base, .fuse_ready);
`default_nettype wire

// [test/tfpa_trim_page_tb.sv]
// Self-checking bench for the trim fuse page overlay
`default_nettype none
module tfpa_trim_page_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [10:0] TEMP = 11'h5a3;
  localparam logic [15:0] REFH = 16'hc3e1;
  localparam logic [7:0] ROOM = 8'h9b;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic [15:0] pm_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic pm_rd = 1'b0;
  logic [7:0] io_wdata = 8'h00;
  wire logic [7:0] io_rdata, pm_rdata, flash_rdata;
  wire logic io_hit, io_valid, pm_valid, pm_from_trim, sel, rdy;
  wire logic [5:0] base;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  tfpa_flash_model flash_u (.addr(pm_addr), .data(flash_rdata));
  tfpa_trim_page #(.SETTLE_CYC(1)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .io_hit(io_hit), .io_valid(io_valid), .pm_addr(pm_addr),
    .pm_rd(pm_rd), .pm_rdata(pm_rdata), .pm_valid(pm_valid), .pm_from_trim(pm_from_trim),
    .flash_rdata(flash_rdata), .fuse_temp_hot(TEMP), .fuse_ref_hot(REFH),
    .fuse_ref_room(ROOM), .trim_page_select(sel), .code_location_base(base),
    .fuse_ready(rdy));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic io_w(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge mclk);
    io_wr = 1'b0;
  endtask
  task automatic io_r(input logic [15:0] a, input logic [7:0] e, input logic h);
    @(negedge mclk);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge mclk);
    io_rd = 1'b0;
    chk("io_valid", 16'h0001, {15'h0, io_valid});
    chk("io_rdata", {8'h00, e}, {8'h00, io_rdata});
    chk("io_hit", {15'h0, h}, {15'h0, io_hit});
  endtask
  task automatic pm_r(input logic [15:0] a, input logic [7:0] e, input logic t);
    @(negedge mclk);
    pm_addr = a;
    pm_rd = 1'b1;
    @(negedge mclk);
    pm_rd = 1'b0;
    chk("pm_valid", 16'h0001, {15'h0, pm_valid});
    chk("pm_rdata", {8'h00, e}, {8'h00, pm_rdata});
    chk("pm_from_trim", {15'h0, t}, {15'h0, pm_from_trim});
  endtask
  task automatic pm_f(input logic [15:0] a);
    pm_r(a, a[7:0] ^ a[15:8] ^ 8'h5a, 1'b0);
  endtask
  task automatic t_regs();
    io_r(16'h270b, 8'h00, 1'b1);
    io_r(16'h2109, 8'h00, 1'b1);
    io_w(16'h2109, 8'hff);
    chk("base", 16'h003f, {10'h0, base});
    io_r(16'h2109, 8'h3f, 1'b1);
    io_w(16'h270b, 8'hff);
    chk("sel", 16'h0001, {15'h0, sel});
    io_r(16'h270b, 8'h01, 1'b1);
    io_r(16'h0091, 8'h00, 1'b0);
    io_w(16'h0092, 8'h55);
    io_r(16'h0092, 8'h00, 1'b0);
    pm_r(16'hfc94, ROOM, 1'b1);
    io_w(16'h270b, 8'h00);
    chk("sel", 16'h0000, {15'h0, sel});
    $display("t_regs done");
  endtask
  task automatic t_over();
    logic [7:0] h;
    io_w(16'h2109, 8'h02);
    io_w(16'h270b, 8'h01);
    pm_r(16'h0890, {5'h00, TEMP[10:8]}, 1'b1);
    h = pm_rdata;
    pm_r(16'h0891, TEMP[7:0], 1'b1);
    chk("temp16", {{5{TEMP[10]}}, TEMP}, {{5{h[2]}}, h[2:0], pm_rdata});
    pm_r(16'h0892, REFH[15:8], 1'b1);
    pm_r(16'h0893, REFH[7:0], 1'b1);
    pm_r(16'h0894, ROOM, 1'b1);
    pm_r(16'h0895, 8'h00, 1'b1);
    pm_f(16'h0c92);
    pm_f(16'h0492);
    io_w(16'h270b, 8'h00);
    pm_f(16'h0892);
    $display("t_over done");
  endtask
  task automatic t_edge();
    io_w(16'h2109, 8'h00);
    io_w(16'h270b, 8'h01);
    pm_r(16'h0093, REFH[7:0], 1'b1);
    pm_f(16'h0493);
    io_w(16'h270b, 8'h00);
    pm_f(16'h0093);
    $display("t_edge done");
  endtask
  task automatic t_reset();
    io_w(16'h2109, 8'h05);
    io_w(16'h270b, 8'h01);
    pm_r(16'h1494, ROOM, 1'b1);
    @(negedge mclk);
    sys_rst = 1'b1;
    repeat (2) @(negedge mclk);
    chk("sel_rst", 16'h0000, {15'h0, sel});
    chk("base_rst", 16'h0000, {10'h0, base});
    chk("rdy_rst", 16'h0000, {15'h0, rdy});
    chk("trim_rst", 16'h0000, {15'h0, pm_from_trim});
    sys_rst = 1'b0;
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(negedge mclk);
    chk("fuse_ready", 16'h0001, {15'h0, rdy});
    pm_f(16'h0094);
    $display("t_reset done");
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    for (int i = 0; i < 50 && rdy !== 1'b1; i++) @(negedge mclk);
    chk("fuse_ready", 16'h0001, {15'h0, rdy});
    t_regs();
    t_over();
    t_edge();
    t_reset();
    wrap_up();
  end
  // Hang guard well above the fewer than one hundred cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      wrap_up();
    end
  end
endmodule
`default_nettype wire
